// [usbfc_map.svh]
// constants for the usb endpoint fifo controller
`ifndef USBFC_MAP_SVH
`define USBFC_MAP_SVH
`define USBFC_FIFO_DEPTH 64
`define USBFC_FIFO_SIZE 7'h40
`define USBFC_PTR_W 6
`define USBFC_CNT_W 7
`define USBFC_LANES 3
`define USBFC_RX_BASE 3
`define USBFC_PTR_ONE 7'h01
`define USBFC_RST_BYTE 8'h00
`define USBFC_RST_CNT 7'h00
`define USBFC_RST_PTR 7'h00
`define USBFC_RST_FLAGS 6'h00
`define USBFC_EV_WARN 0
`define USBFC_EV_TXUNDR 1
`define USBFC_EV_RXOVR 2
`define USBFC_GLOBAL_EN 7
`endif

// [usbfc_pkg.sv]
// types and count helpers for the usb endpoint fifo controller
`default_nettype none
`include "usbfc_map.svh"
package usbfc_pkg;
	typedef logic [7:0] usbfc_byte_t;
	typedef logic [`USBFC_CNT_W-1:0] usbfc_cnt_t;
	typedef logic [`USBFC_PTR_W:0] usbfc_wptr_t;
	typedef logic [`USBFC_LANES-1:0][7:0] usbfc_lane_bytes_t;
	typedef logic [`USBFC_LANES-1:0][`USBFC_CNT_W-1:0] usbfc_lane_cnt_t;
	typedef logic [2*`USBFC_LANES-1:0] usbfc_flags_t;

	// fill level from pointers carrying one wrap bit
	function automatic usbfc_cnt_t usbfc_level(input usbfc_wptr_t wp, input usbfc_wptr_t rp);
		usbfc_wptr_t d;
		d = wp - rp;
		return usbfc_cnt_t'(d);
	endfunction

	// free bytes left for a given fill level
	function automatic usbfc_cnt_t usbfc_space(input usbfc_cnt_t level);
		return `USBFC_FIFO_SIZE - level;
	endfunction
endpackage
`default_nettype wire

// [usbfc_fifo_if.sv]
// carrier between the controller and one ring buffer
`default_nettype none
interface usbfc_fifo_if;
	import usbfc_pkg::*;
	logic push;
	logic pop;
	usbfc_byte_t wdata;
	usbfc_byte_t rdata;
	usbfc_cnt_t level;
	modport core (input push, input pop, input wdata, output rdata, output level);
	modport user (output push, output pop, output wdata, input rdata, input level);
endinterface
`default_nettype wire

// [usbfc_ring.sv]
// one 64-byte circular endpoint buffer
`default_nettype none
`include "usbfc_map.svh"
module usbfc_ring (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	usbfc_fifo_if.core fif
);
	import usbfc_pkg::*;

	usbfc_byte_t mem [0:`USBFC_FIFO_DEPTH-1];
	usbfc_wptr_t wp_reg, wp_next;
	usbfc_wptr_t rp_reg, rp_next;
	usbfc_byte_t rdata_reg, rdata_next;
	logic do_push, do_pop;

	// =====================================================
	// pointer and read data next values
	always_comb begin
		fif.level = usbfc_level(wp_reg, rp_reg);
		do_push = fif.push && (fif.level != `USBFC_FIFO_SIZE);
		do_pop = fif.pop && (fif.level != `USBFC_RST_CNT);
		wp_next = do_push ? wp_reg + `USBFC_PTR_ONE : wp_reg;
		rp_next = do_pop ? rp_reg + `USBFC_PTR_ONE : rp_reg;
		rdata_next = do_pop ? mem[rp_reg[`USBFC_PTR_W-1:0]] : rdata_reg;
	end

	// registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wp_reg <= `USBFC_RST_PTR;
			rp_reg <= `USBFC_RST_PTR;
			rdata_reg <= `USBFC_RST_BYTE;
		end else if (clk_en) begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			rdata_reg <= rdata_next;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_sys) begin
		if (clk_en && do_push && !sys_rst) begin
			mem[wp_reg[`USBFC_PTR_W-1:0]] <= fif.wdata;
		end
	end

	assign fif.rdata = rdata_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_ring_level_bound: assert property (fif.level <= `USBFC_FIFO_SIZE)
		else $error("ring level above size");
	a_ring_full_drop: assert property (clk_en && fif.push && !fif.pop && fif.level == `USBFC_FIFO_SIZE
		|=> wp_reg == $past(wp_reg) && fif.level == `USBFC_FIFO_SIZE)
		else $error("write into full ring changed it");
	a_ring_empty_repeat: assert property (clk_en && fif.pop && fif.level == `USBFC_RST_CNT
		|=> rp_reg == $past(rp_reg) && fif.rdata == $past(fif.rdata))
		else $error("read of empty ring moved pointer or data");
	a_ring_pop_step: assert property (clk_en && fif.pop && fif.level != `USBFC_RST_CNT
		|=> rp_reg[`USBFC_PTR_W-1:0] == $past(rp_reg[`USBFC_PTR_W-1:0]) + 6'h01)
		else $error("read pointer did not step by one");
endmodule
`default_nettype wire

// [usbfc_top.sv]
// usb endpoint fifo controller: three tx and three rx rings with event hierarchy
`default_nettype none
`include "usbfc_map.svh"
module usbfc_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [`USBFC_LANES-1:0] fw_tx_wr,
	input wire usbfc_pkg::usbfc_byte_t fw_tx_data,
	input wire logic [`USBFC_LANES-1:0] ep_tx_rd,
	input wire logic [`USBFC_LANES-1:0] tx_last_cmd,
	output logic [`USBFC_LANES-1:0][7:0] ep_tx_data,
	input wire usbfc_pkg::usbfc_lane_cnt_t tx_warn_threshold,
	output usbfc_pkg::usbfc_lane_cnt_t tx_free_count,
	input wire logic [`USBFC_LANES-1:0] ep_rx_wr,
	input wire usbfc_pkg::usbfc_byte_t ep_rx_data,
	input wire logic [`USBFC_LANES-1:0] fw_rx_rd,
	output logic [`USBFC_LANES-1:0][7:0] fw_rx_data,
	input wire usbfc_pkg::usbfc_lane_cnt_t rx_warn_threshold,
	output usbfc_pkg::usbfc_lane_cnt_t rx_unread_count,
	output usbfc_pkg::usbfc_lane_cnt_t rx_space_left,
	output logic [`USBFC_LANES-1:0] tx_underrun,
	output logic [`USBFC_LANES-1:0] rx_overrun,
	input wire usbfc_pkg::usbfc_flags_t err_clear,
	input wire usbfc_pkg::usbfc_flags_t err_mask,
	output usbfc_pkg::usbfc_flags_t fifo_warning_reg,
	input wire usbfc_pkg::usbfc_flags_t warn_clear,
	input wire usbfc_pkg::usbfc_flags_t warn_mask,
	output logic [7:0] main_event_reg,
	input wire logic [7:0] main_mask_reg,
	output logic usb_cpu_irq
);
	import usbfc_pkg::*;

	usbfc_lane_cnt_t tx_level;
	usbfc_lane_cnt_t rx_level;

	// =====================================================
	// ring instances, sized at 64 bytes each
	for (genvar i = 0; i < `USBFC_LANES; i++) begin : g_lane
		usbfc_fifo_if tx_if();
		usbfc_fifo_if rx_if();

		// firmware fills, endpoint controller drains
		assign tx_if.push = fw_tx_wr[i];
		assign tx_if.wdata = fw_tx_data;
		assign tx_if.pop = ep_tx_rd[i];
		assign ep_tx_data[i] = tx_if.rdata;
		assign tx_level[i] = tx_if.level;

		// endpoint controller fills, firmware drains
		assign rx_if.push = ep_rx_wr[i];
		assign rx_if.wdata = ep_rx_data;
		assign rx_if.pop = fw_rx_rd[i];
		assign fw_rx_data[i] = rx_if.rdata;
		assign rx_level[i] = rx_if.level;

		usbfc_ring u_tx_ring (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.clk_en(clk_en),
			.fif(tx_if)
		);
		usbfc_ring u_rx_ring (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.clk_en(clk_en),
			.fif(rx_if)
		);
	end

	// =====================================================
	// status counts
	usbfc_lane_cnt_t tx_free_reg, tx_free_next;
	usbfc_lane_cnt_t rx_unread_reg, rx_unread_next;
	usbfc_lane_cnt_t rx_space_reg, rx_space_next;

	// counts derived from the ring levels
	always_comb begin
		for (int k = 0; k < `USBFC_LANES; k++) begin
			tx_free_next[k] = usbfc_space(tx_level[k]);
			rx_unread_next[k] = rx_level[k];
			rx_space_next[k] = usbfc_space(rx_level[k]);
		end
	end

	// count registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_free_reg <= {`USBFC_LANES{`USBFC_FIFO_SIZE}};
			rx_unread_reg <= {`USBFC_LANES{`USBFC_RST_CNT}};
			rx_space_reg <= {`USBFC_LANES{`USBFC_FIFO_SIZE}};
		end else if (clk_en) begin
			tx_free_reg <= tx_free_next;
			rx_unread_reg <= rx_unread_next;
			rx_space_reg <= rx_space_next;
		end
	end

	assign tx_free_count = tx_free_reg;
	assign rx_unread_count = rx_unread_reg;
	assign rx_space_left = rx_space_reg;

	// =====================================================
	// sticky error and warning flags
	usbfc_flags_t err_reg, err_next;
	usbfc_flags_t warn_reg, warn_next;
	usbfc_flags_t err_set, warn_set;

	// set beats clear in the same cycle
	always_comb begin
		for (int k = 0; k < `USBFC_LANES; k++) begin
			err_set[k] = ep_tx_rd[k] && (tx_level[k] == `USBFC_RST_CNT) && !tx_last_cmd[k];
			err_set[k + `USBFC_RX_BASE] = ep_rx_wr[k] && (rx_level[k] == `USBFC_FIFO_SIZE);
			warn_set[k] = tx_level[k] <= tx_warn_threshold[k];
			warn_set[k + `USBFC_RX_BASE] = usbfc_space(rx_level[k]) <= rx_warn_threshold[k];
		end
		err_next = (err_reg & ~err_clear) | err_set;
		warn_next = (warn_reg & ~warn_clear) | warn_set;
	end

	// flag registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			err_reg <= `USBFC_RST_FLAGS;
			warn_reg <= `USBFC_RST_FLAGS;
		end else if (clk_en) begin
			err_reg <= err_next;
			warn_reg <= warn_next;
		end
	end

	assign tx_underrun = err_reg[`USBFC_LANES-1:0];
	assign rx_overrun = err_reg[2*`USBFC_LANES-1:`USBFC_RX_BASE];
	assign fifo_warning_reg = warn_reg;

	// =====================================================
	// main event register and cpu interrupt
	logic [7:0] main_ev_reg, main_ev_next;
	logic irq_reg, irq_next;

	// masked lower events propagate upward
	always_comb begin
		main_ev_next = 8'h00;
		main_ev_next[`USBFC_EV_WARN] = |(warn_reg & warn_mask);
		main_ev_next[`USBFC_EV_TXUNDR] = |(err_reg[`USBFC_LANES-1:0] & err_mask[`USBFC_LANES-1:0]);
		main_ev_next[`USBFC_EV_RXOVR] = |(err_reg[2*`USBFC_LANES-1:`USBFC_RX_BASE]
			& err_mask[2*`USBFC_LANES-1:`USBFC_RX_BASE]);
		irq_next = main_mask_reg[`USBFC_GLOBAL_EN]
			&& |(main_ev_reg[`USBFC_GLOBAL_EN-1:0] & main_mask_reg[`USBFC_GLOBAL_EN-1:0]);
	end

	// event and interrupt registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			main_ev_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else if (clk_en) begin
			main_ev_reg <= main_ev_next;
			irq_reg <= irq_next;
		end
	end

	assign main_event_reg = main_ev_reg;
	assign usb_cpu_irq = irq_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	for (genvar j = 0; j < `USBFC_LANES; j++) begin : g_chk
		a_tx_underrun_set: assert property (clk_en && ep_tx_rd[j] && tx_level[j] == `USBFC_RST_CNT
			&& !tx_last_cmd[j] |=> tx_underrun[j])
			else $error("tx underrun not flagged");
		a_tx_last_quiet: assert property (clk_en && ep_tx_rd[j] && tx_last_cmd[j] && !tx_underrun[j]
			&& !err_clear[j] |=> !tx_underrun[j])
			else $error("tx underrun flagged with last set");
		a_rx_overrun_set: assert property (clk_en && ep_rx_wr[j] && rx_level[j] == `USBFC_FIFO_SIZE
			|=> rx_overrun[j])
			else $error("rx overrun not flagged");
		a_tx_free_sum: assert property (clk_en |=> tx_free_count[j] + $past(tx_level[j])
			== `USBFC_FIFO_SIZE)
			else $error("tx free count wrong");
		a_tx_warn_set: assert property (clk_en && tx_level[j] <= tx_warn_threshold[j]
			|=> fifo_warning_reg[j])
			else $error("tx warning missing");
		a_rx_warn_set: assert property (clk_en && rx_space_next[j] <= rx_warn_threshold[j]
			|=> fifo_warning_reg[j + `USBFC_RX_BASE])
			else $error("rx warning missing");
		a_rx_unread_track: assert property (clk_en |=> rx_unread_count[j] == $past(rx_level[j]))
			else $error("rx unread count wrong");
	end

	a_irq_global_off: assert property (clk_en && !main_mask_reg[`USBFC_GLOBAL_EN] |=> !usb_cpu_irq)
		else $error("irq raised while globally disabled");
	a_irq_raise: assert property (clk_en && main_mask_reg[`USBFC_GLOBAL_EN]
		&& |(main_event_reg[`USBFC_GLOBAL_EN-1:0] & main_mask_reg[`USBFC_GLOBAL_EN-1:0])
		|=> usb_cpu_irq)
		else $error("irq not raised for masked event");
	a_warn_mask_gate: assert property (clk_en && !(|warn_mask) |=> !main_event_reg[`USBFC_EV_WARN])
		else $error("masked warning reached main event");
endmodule
`default_nettype wire

// [usbfc_ep_model.sv]
// endpoint controller model: fetches tx bytes and stores rx bytes
`default_nettype none
module usbfc_ep_model (
	input wire logic clk_sys,
	input wire usbfc_pkg::usbfc_lane_bytes_t ep_tx_data,
	output var logic [2:0] ep_tx_rd,
	output var logic [2:0] tx_last_cmd,
	output var logic [2:0] ep_rx_wr,
	output var usbfc_pkg::usbfc_byte_t ep_rx_data
);
	import usbfc_pkg::*;
	usbfc_byte_t seen[$];
	// idle strobes at time zero
	initial begin
		ep_tx_rd = '0;
		tx_last_cmd = '0;
		ep_rx_wr = '0;
		ep_rx_data = 8'h00;
	end
	// =====================
	// fetch n bytes back to back, keep what came out
	task automatic fetch(input int l, input int n, input logic last);
		tx_last_cmd[l] = last;
		for (int i = 0; i < n; i++) begin
			ep_tx_rd[l] = 1'b1;
			@(posedge clk_sys);
			#1;
			seen.push_back(ep_tx_data[l]);
		end
		ep_tx_rd = '0;
	endtask
	// store n counting bytes, then show the inverse on the idle line
	task automatic store(input int l, input int n, input usbfc_byte_t b);
		for (int i = 0; i < n; i++) begin
			ep_rx_wr[l] = 1'b1;
			ep_rx_data = b + 8'(i);
			@(posedge clk_sys);
			#1;
		end
		ep_rx_wr = '0;
		ep_rx_data = ~ep_rx_data;
	endtask
endmodule
`default_nettype wire

// [usbfc_top_test.sv]
// self-checking bench for the usb endpoint fifo controller
`default_nettype none
module usbfc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import usbfc_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [2:0] fw_tx_wr = '0, fw_rx_rd = '0, ep_tx_rd, ep_rx_wr, tx_last_cmd, tx_underrun, rx_overrun;
	usbfc_byte_t fw_tx_data = 8'h00, ep_rx_data;
	usbfc_lane_bytes_t ep_tx_data, fw_rx_data;
	usbfc_lane_cnt_t tx_warn_threshold = {7'h00, 7'h00, 7'h02}, rx_warn_threshold = {7'h00, 7'h01, 7'h00};
	usbfc_lane_cnt_t tx_free_count, rx_unread_count, rx_space_left;
	usbfc_flags_t err_clear = '0, err_mask = '0, warn_clear = '0, warn_mask = '0, fifo_warning_reg;
	logic [7:0] main_event_reg, main_mask_reg = 8'h00;
	logic usb_cpu_irq;
	int n_mismatch = 0;
	int checks_done = 0;
	// =====================
	// design and endpoint partner
	usbfc_top usbfc_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .fw_tx_wr(fw_tx_wr),
		.fw_tx_data(fw_tx_data), .ep_tx_rd(ep_tx_rd), .tx_last_cmd(tx_last_cmd), .ep_tx_data(ep_tx_data),
		.tx_warn_threshold(tx_warn_threshold), .tx_free_count(tx_free_count), .ep_rx_wr(ep_rx_wr),
		.ep_rx_data(ep_rx_data), .fw_rx_rd(fw_rx_rd), .fw_rx_data(fw_rx_data), .rx_warn_threshold(rx_warn_threshold),
		.rx_unread_count(rx_unread_count), .rx_space_left(rx_space_left), .tx_underrun(tx_underrun),
		.rx_overrun(rx_overrun), .err_clear(err_clear), .err_mask(err_mask), .fifo_warning_reg(fifo_warning_reg),
		.warn_clear(warn_clear), .warn_mask(warn_mask), .main_event_reg(main_event_reg),
		.main_mask_reg(main_mask_reg), .usb_cpu_irq(usb_cpu_irq));
	usbfc_ep_model usbfc_ep_model_inst (.clk_sys(clk_sys), .ep_tx_data(ep_tx_data), .ep_tx_rd(ep_tx_rd),
		.tx_last_cmd(tx_last_cmd), .ep_rx_wr(ep_rx_wr), .ep_rx_data(ep_rx_data));
	// clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// =====================
	// shared helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// =====================
	// fill tx lane past full, drain around the warning boundary, underrun
	task automatic t_tx;
		for (int i = 0; i < 65; i++) begin
			fw_tx_wr = 3'b001;
			fw_tx_data = 8'h10 + 8'(i);
			step(1);
		end
		fw_tx_wr = '0;
		warn_clear = 6'h01;
		step(1);
		warn_clear = '0;
		step(2);
		chk(tx_free_count[0] === 7'h00, "tx free count at full");
		chk(fifo_warning_reg[0] === 1'b0, "tx warning above threshold");
		usbfc_ep_model_inst.fetch(0, 61, 1'b0);
		step(2);
		chk(fifo_warning_reg[0] === 1'b0, "tx warning at level 3");
		usbfc_ep_model_inst.fetch(0, 1, 1'b0);
		step(2);
		chk(fifo_warning_reg[0] === 1'b1, "tx warning at level 2");
		usbfc_ep_model_inst.fetch(0, 2, 1'b0);
		step(2);
		for (int i = 0; i < 64; i++) begin
			chk(usbfc_ep_model_inst.seen[i] === 8'h10 + 8'(i), "tx byte order");
		end
		chk(tx_free_count[0] === 7'h40 && tx_underrun === 3'b000, "tx empty clean");
		usbfc_ep_model_inst.fetch(0, 1, 1'b1);
		step(2);
		chk(tx_underrun[0] === 1'b0, "underrun with last set");
		usbfc_ep_model_inst.fetch(0, 1, 1'b0);
		step(1);
		chk(tx_underrun[0] === 1'b1, "underrun missing");
		fw_tx_wr = 3'b001;
		fw_tx_data = 8'hA5;
		step(1);
		fw_tx_wr = '0;
		usbfc_ep_model_inst.fetch(0, 1, 1'b0);
		chk(usbfc_ep_model_inst.seen[$] === 8'hA5, "tx wrap byte");
	endtask
	// masks, global enable and interrupt
	task automatic t_irq;
		step(3);
		chk(main_event_reg === 8'h00, "masked underrun passed");
		err_mask = 6'h01;
		main_mask_reg = 8'h02;
		step(3);
		chk(main_event_reg === 8'h02 && usb_cpu_irq === 1'b0, "global enable off");
		main_mask_reg = 8'h82;
		step(2);
		chk(usb_cpu_irq === 1'b1, "irq missing");
		err_clear = 6'h01;
		step(1);
		err_clear = '0;
		step(3);
		chk(usb_cpu_irq === 1'b0, "irq after clear");
	endtask
	// fill rx lane past full, drain, read past empty
	task automatic t_rx;
		usbfc_ep_model_inst.store(1, 64, 8'hC0);
		step(2);
		chk(rx_unread_count[1] === 7'h40 && rx_space_left[1] === 7'h00, "rx counts full");
		chk(fifo_warning_reg[4] === 1'b1, "rx warning");
		usbfc_ep_model_inst.store(1, 1, 8'h77);
		step(1);
		chk(rx_overrun[1] === 1'b1 && main_event_reg === 8'h00, "rx overrun");
		for (int i = 0; i < 65; i++) begin
			fw_rx_rd = 3'b010;
			step(1);
			chk(fw_rx_data[1] === 8'hC0 + 8'(i < 64 ? i : 63), "rx byte");
		end
		fw_rx_rd = '0;
		step(2);
		chk(rx_unread_count[1] === 7'h00 && rx_space_left[1] === 7'h40, "rx counts empty");
	endtask
	// clock enable low freezes the rings, then one enabled write lands
	task automatic t_hold;
		clk_en = 1'b0;
		fw_tx_wr = 3'b010;
		fw_tx_data = 8'h3C;
		step(3);
		fw_tx_wr = '0;
		clk_en = 1'b1;
		step(2);
		chk(tx_free_count[1] === 7'h40, "write taken while frozen");
		fw_tx_wr = 3'b010;
		step(1);
		fw_tx_wr = '0;
		step(2);
		chk(tx_free_count[1] === 7'h3F, "write lost after enable");
	endtask
	// =====================
	// main sequence
	initial begin
		step(2);
		chk(tx_free_count[0] === 7'h40 && rx_unread_count === '0 && usb_cpu_irq === 1'b0, "reset");
		sys_rst = 1'b0;
		t_tx();
		t_irq();
		t_rx();
		t_hold();
		end_sim();
	end
	// watchdog
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
